// ===== rtl/regl_pkg.sv
// shared constants and types for the rail enable gating block
package regl_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] REG_IDX_PG_MASK_MAIN = 6'h13;
   localparam logic [5:0] REG_IDX_SRC_AND_MASK = 6'h14;
   localparam logic [5:0] REG_IDX_EDGE_DELAY   = 6'h15;
   localparam logic [5:0] REG_IDX_STATUS       = 6'h1F;

   // reset values of the writable registers
   localparam logic [7:0] RST_PG_MASK_MAIN = 8'h00;
   localparam logic [1:0] RST_PG_MASK_SIDE = 2'h0;
   localparam logic [2:0] RST_SRC_SELECT   = 3'h0;
   localparam logic [2:0] RST_FALL_DELAY   = 3'h0;
   localparam logic [2:0] RST_RISE_DELAY   = 3'h0;

   // field positions
   localparam int SRC_SEL_LSB   = 2;
   localparam int SRC_SEL_MSB   = 4;
   localparam int MASK_B1_BIT   = 0;
   localparam int MASK_B2_BIT   = 1;
   localparam int RISE_DLY_LSB  = 0;
   localparam int RISE_DLY_MSB  = 2;
   localparam int FALL_DLY_LSB  = 3;
   localparam int FALL_DLY_MSB  = 5;

   // enable source codes
   localparam logic [2:0] SRC_CTL_ONE    = 3'h0;
   localparam logic [2:0] SRC_CTL_TWO    = 3'h1;
   localparam logic [2:0] SRC_CTL_FIVE   = 3'h2;
   localparam logic [2:0] SRC_CTL_FOUR   = 3'h3;
   localparam logic [2:0] SRC_CTL_THREE  = 3'h4;
   localparam logic [2:0] SRC_CTL_3_AND_4 = 3'h5;
   localparam logic [2:0] SRC_CTL_SIX    = 3'h6;
   localparam logic [2:0] SRC_CONST_ONE  = 3'h7;

   // edge delays in milliseconds, one per code
   localparam logic [6:0] DLY_MS_0 = 7'h00;
   localparam logic [6:0] DLY_MS_1 = 7'h02;
   localparam logic [6:0] DLY_MS_2 = 7'h04;
   localparam logic [6:0] DLY_MS_3 = 7'h08;
   localparam logic [6:0] DLY_MS_4 = 7'h10;
   localparam logic [6:0] DLY_MS_5 = 7'h18;
   localparam logic [6:0] DLY_MS_6 = 7'h20;
   localparam logic [6:0] DLY_MS_7 = 7'h40;

   // timebase: one millisecond tick at the core clock
   localparam int CLK_FREQ_KHZ   = 200000;
   localparam int TICK_MS        = 1;
   localparam int MS_TICK_CYCLES = TICK_MS * CLK_FREQ_KHZ;

   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

   // edge delay states, gray along low -> rise -> high -> fall
   typedef enum logic [1:0] {
      DLY_LOW  = 2'b00,
      DLY_RISE = 2'b01,
      DLY_HIGH = 2'b11,
      DLY_FALL = 2'b10
   } regl_dly_state_t;

endpackage : regl_pkg

// ===== rtl/regl_edge_delay.sv
// separate rise and fall qualification delay for one enable level
`timescale 1ns/10ps
module regl_edge_delay #(
   parameter int MS_CYCLES = regl_pkg::MS_TICK_CYCLES
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       level_in,
   input  wire logic [6:0] rise_ms_in,
   input  wire logic [6:0] fall_ms_in,
   output logic            level_out,
   output logic            busy_out
);
   localparam int CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   regl_pkg::regl_dly_state_t state_q;
   regl_pkg::regl_dly_state_t state_d;
   logic [CW-1:0]             cyc_q;
   logic [6:0]                ms_q;
   logic                      ms_wrap;
   logic                      rise_done;
   logic                      fall_done;

   // >= keeps a shortened delay from overrunning when software rewrites it
   assign ms_wrap   = (cyc_q == CW'(MS_CYCLES - 1));
   assign rise_done = (ms_q >= rise_ms_in);
   assign fall_done = (ms_q >= fall_ms_in);

   // a level that reverts before its delay ends is dropped as a glitch
   always_comb begin
      state_d = state_q;
      case (state_q)
         regl_pkg::DLY_LOW: begin
            if (level_in) begin
               state_d = (rise_ms_in == 7'h00) ? regl_pkg::DLY_HIGH
                                               : regl_pkg::DLY_RISE;
            end
         end
         regl_pkg::DLY_RISE: begin
            if (!level_in) begin
               state_d = regl_pkg::DLY_LOW;
            end else if (rise_done) begin
               state_d = regl_pkg::DLY_HIGH;
            end
         end
         regl_pkg::DLY_HIGH: begin
            if (!level_in) begin
               state_d = (fall_ms_in == 7'h00) ? regl_pkg::DLY_LOW
                                               : regl_pkg::DLY_FALL;
            end
         end
         regl_pkg::DLY_FALL: begin
            if (level_in) begin
               state_d = regl_pkg::DLY_HIGH;
            end else if (fall_done) begin
               state_d = regl_pkg::DLY_LOW;
            end
         end
         default: state_d = regl_pkg::DLY_LOW;
      endcase
   end

   // state and output flop
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q   <= regl_pkg::DLY_LOW;
         level_out <= 1'b0;
         busy_out  <= 1'b0;
      end else if (ce_in) begin
         state_q   <= state_d;
         level_out <= (state_d == regl_pkg::DLY_HIGH) ||
                      (state_d == regl_pkg::DLY_FALL);
         busy_out  <= (state_d == regl_pkg::DLY_RISE) ||
                      (state_d == regl_pkg::DLY_FALL);
      end
   end

   // millisecond counter restarts on every state change for exact delays
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cyc_q <= '0;
         ms_q  <= 7'h00;
      end else if (ce_in) begin
         if (state_d != state_q || state_q == regl_pkg::DLY_LOW ||
             state_q == regl_pkg::DLY_HIGH) begin
            cyc_q <= '0;
            ms_q  <= 7'h00;
         end else if (ms_wrap) begin
            cyc_q <= '0;
            ms_q  <= ms_q + 7'h01;
         end else begin
            cyc_q <= cyc_q + CW'(1);
         end
      end
   end

endmodule // regl_edge_delay

// ===== rtl/regl_top.sv
// rail five enable gating: source select, edge delays, power-good gating
//
// What this block does
// - mask register one bits 7..0 cover ldo a3, ldo a2, switch a1, rails 6,4,3,2,1; a 0 puts that flag into the enable condition.
// - a mask bit at 1 removes that rail's power-good flag from the enable condition entirely.
// - register two bit 1 masks switch b2/ldo a1 and bit 0 masks switch b1, with 0 including and 1 excluding.
// - register two bits 4:2 pick the enable input: 000 one, 001 two, 010 five, 011 four, 100 three, 110 six.
// - source code 101 enables only when control inputs three and four are both high.
// - source code 111 feeds a constant one, so no control input is needed.
// - register three bits 5:3 delay the falling edge: none, 2, 4, 8, 16, 24, 32, 64 ms.
// - register three bits 2:0 delay the rising edge with the same code mapping.
`timescale 1ns/10ps
module regl_top #(
   parameter int MS_CYCLES = regl_pkg::MS_TICK_CYCLES,
   parameter int ADDR_W    = 8,
   parameter int N_CTL     = 6,
   parameter int N_PG      = 10
) (
   input  wire logic              CLK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic              CE_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [ADDR_W-1:0] PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   input  wire logic [3:0]        PSTRB_IN,
   input  wire logic [N_CTL-1:0]  CONTROL_INPUT_IN,
   input  wire logic [N_PG-1:0]   POWER_GOOD_FLAG_IN,
   output logic [31:0]            PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   output logic                   RAIL_ENABLE_OUT
);
   localparam int NS = N_CTL + N_PG;

   // reset release
   logic            rst_meta_n_q;
   logic            rst_n_q;

   // pin synchronisers
   logic [NS-1:0]   sync_meta_q;
   logic [NS-1:0]   sync_q;
   logic [N_CTL-1:0] ctl_s;
   logic [N_PG-1:0] pg_s;
   logic [NS-1:0]   pin_raw;

   // software registers
   logic [7:0]      mask_main_q;
   logic [1:0]      mask_side_q;
   logic [2:0]      src_sel_q;
   logic [2:0]      fall_code_q;
   logic [2:0]      rise_code_q;

   // bus decode
   logic [5:0]      word_idx;
   logic            hit_main;
   logic            hit_side;
   logic            hit_delay;
   logic            hit_status;
   logic            mapped;
   logic            access;
   logic            wr_take;
   logic [31:0]     rd_data;

   // enable path
   logic            sel_level;
   logic [6:0]      rise_ms;
   logic [6:0]      fall_ms;
   logic            delayed_en;
   logic            delay_busy;
   logic [N_PG-1:0] mask_vec;
   logic            pg_ok;

   // asynchronous assert, synchronous release through two flops
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rst_meta_n_q <= 1'b0;
         rst_n_q      <= 1'b0;
      end else begin
         rst_meta_n_q <= 1'b1;
         rst_n_q      <= rst_meta_n_q;
      end
   end

   // two-flop synchronisers; only the second stage is read by logic
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge CLK_IN or negedge rst_n_q) begin
            if (!rst_n_q) begin
               sync_meta_q[gi] <= 1'b0;
               sync_q[gi]      <= 1'b0;
            end else if (CE_IN) begin
               sync_meta_q[gi] <= pin_raw[gi];
               sync_q[gi]      <= sync_meta_q[gi];
            end
         end
      end
   endgenerate

   // one flat vector keeps every pin index in range
   assign pin_raw = {POWER_GOOD_FLAG_IN, CONTROL_INPUT_IN};

   assign ctl_s = sync_q[N_CTL-1:0];
   assign pg_s  = sync_q[NS-1:N_CTL];

   // word decode; low address bits are ignored since every register is a word
   assign word_idx   = PADDR_IN[7:2];
   assign hit_main   = (word_idx == regl_pkg::REG_IDX_PG_MASK_MAIN);
   assign hit_side   = (word_idx == regl_pkg::REG_IDX_SRC_AND_MASK);
   assign hit_delay  = (word_idx == regl_pkg::REG_IDX_EDGE_DELAY);
   assign hit_status = (word_idx == regl_pkg::REG_IDX_STATUS);
   assign mapped     = hit_main | hit_side | hit_delay | hit_status;

   // one wait state: pready rises in the second access cycle
   assign access  = PSEL_IN & PENABLE_IN;
   assign wr_take = access & PREADY_OUT & PWRITE_IN & PSTRB_IN[0] & mapped;

   // bus handshake flops
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
      end else if (CE_IN) begin
         PREADY_OUT  <= access & ~PREADY_OUT;
         PSLVERR_OUT <= access & ~PREADY_OUT & ~mapped;
         if (access & ~PREADY_OUT & ~PWRITE_IN) begin
            PRDATA_OUT <= rd_data;
         end else if (PREADY_OUT) begin
            PRDATA_OUT <= 32'h0000_0000;
         end
      end
   end

   // power-good mask register, all eight bits writable
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_main_q <= regl_pkg::RST_PG_MASK_MAIN;
      end else if (CE_IN && wr_take && hit_main) begin
         mask_main_q <= PWDATA_IN[7:0];
      end
   end

   // source select and side masks; reserved bits are not stored
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_side_q <= regl_pkg::RST_PG_MASK_SIDE;
         src_sel_q   <= regl_pkg::RST_SRC_SELECT;
      end else if (CE_IN && wr_take && hit_side) begin
         mask_side_q[0] <= PWDATA_IN[regl_pkg::MASK_B1_BIT];
         mask_side_q[1] <= PWDATA_IN[regl_pkg::MASK_B2_BIT];
         src_sel_q <= PWDATA_IN[regl_pkg::SRC_SEL_MSB:regl_pkg::SRC_SEL_LSB];
      end
   end

   // edge delay codes
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fall_code_q <= regl_pkg::RST_FALL_DELAY;
         rise_code_q <= regl_pkg::RST_RISE_DELAY;
      end else if (CE_IN && wr_take && hit_delay) begin
         fall_code_q <=
            PWDATA_IN[regl_pkg::FALL_DLY_MSB:regl_pkg::FALL_DLY_LSB];
         rise_code_q <=
            PWDATA_IN[regl_pkg::RISE_DLY_MSB:regl_pkg::RISE_DLY_LSB];
      end
   end

   // read mux; unused bits and reserved fields read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit_main) begin
         rd_data[7:0] = mask_main_q;
      end else if (hit_side) begin
         rd_data[regl_pkg::MASK_B1_BIT] = mask_side_q[0];
         rd_data[regl_pkg::MASK_B2_BIT] = mask_side_q[1];
         rd_data[regl_pkg::SRC_SEL_MSB:regl_pkg::SRC_SEL_LSB] = src_sel_q;
      end else if (hit_delay) begin
         rd_data[regl_pkg::FALL_DLY_MSB:regl_pkg::FALL_DLY_LSB] = fall_code_q;
         rd_data[regl_pkg::RISE_DLY_MSB:regl_pkg::RISE_DLY_LSB] = rise_code_q;
      end else if (hit_status) begin
         rd_data[0] = sel_level;
         rd_data[1] = delayed_en;
         rd_data[2] = delay_busy;
         rd_data[3] = pg_ok;
         rd_data[4] = RAIL_ENABLE_OUT;
      end
   end

   // enable source selector; index 0 is control input one
   always_comb begin
      case (src_sel_q)
         regl_pkg::SRC_CTL_ONE:     sel_level = ctl_s[0];
         regl_pkg::SRC_CTL_TWO:     sel_level = ctl_s[1];
         regl_pkg::SRC_CTL_FIVE:    sel_level = ctl_s[4];
         regl_pkg::SRC_CTL_FOUR:    sel_level = ctl_s[3];
         regl_pkg::SRC_CTL_THREE:   sel_level = ctl_s[2];
         regl_pkg::SRC_CTL_3_AND_4: sel_level = ctl_s[2] & ctl_s[3];
         regl_pkg::SRC_CTL_SIX:     sel_level = ctl_s[5];
         regl_pkg::SRC_CONST_ONE:   sel_level = 1'b1;
         default:                   sel_level = 1'b0;
      endcase
   end

   // code to milliseconds; both edge fields share one table
   function automatic logic [6:0] code_to_ms(input logic [2:0] code);
      case (code)
         3'h0:    code_to_ms = regl_pkg::DLY_MS_0;
         3'h1:    code_to_ms = regl_pkg::DLY_MS_1;
         3'h2:    code_to_ms = regl_pkg::DLY_MS_2;
         3'h3:    code_to_ms = regl_pkg::DLY_MS_3;
         3'h4:    code_to_ms = regl_pkg::DLY_MS_4;
         3'h5:    code_to_ms = regl_pkg::DLY_MS_5;
         3'h6:    code_to_ms = regl_pkg::DLY_MS_6;
         3'h7:    code_to_ms = regl_pkg::DLY_MS_7;
         default: code_to_ms = regl_pkg::DLY_MS_0;
      endcase
   endfunction

   assign rise_ms = code_to_ms(rise_code_q);
   assign fall_ms = code_to_ms(fall_code_q);

   // delays are exact cycle counts; the ten percent spread is analog only
   regl_edge_delay #(
      .MS_CYCLES (MS_CYCLES)
   ) u_edge_delay (
      .clk_in     (CLK_IN),
      .rst_n_in   (rst_n_q),
      .ce_in      (CE_IN),
      .level_in   (sel_level),
      .rise_ms_in (rise_ms),
      .fall_ms_in (fall_ms),
      .level_out  (delayed_en),
      .busy_out   (delay_busy)
   );

   // a set mask bit forces that flag to count as good
   assign mask_vec = {mask_side_q, mask_main_q};
   assign pg_ok    = &(pg_s | mask_vec);

   // final enable flop; a lost power-good drops the rail without delay
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         RAIL_ENABLE_OUT <= 1'b0;
      end else if (CE_IN) begin
         RAIL_ENABLE_OUT <= delayed_en & pg_ok;
      end
   end

endmodule // regl_top

// ===== bench/regl_sva.sv
// assertions on the rail five enable gating top ports
`timescale 1ns/10ps
module regl_sva #(
   parameter int MS_CYCLES = 10,
   parameter int ADDR_W    = 8,
   parameter int N_CTL     = 6,
   parameter int N_PG      = 10
) (
   input wire logic              CLK_IN,
   input wire logic              RST_N_IN,
   input wire logic              CE_IN,
   input wire logic              PSEL_IN,
   input wire logic              PENABLE_IN,
   input wire logic              PWRITE_IN,
   input wire logic [ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0]       PWDATA_IN,
   input wire logic [3:0]        PSTRB_IN,
   input wire logic [N_CTL-1:0]  CONTROL_INPUT_IN,
   input wire logic [N_PG-1:0]   POWER_GOOD_FLAG_IN,
   input wire logic              PREADY_OUT,
   input wire logic              RAIL_ENABLE_OUT
);
   localparam logic [6:0] DMS [8] = '{7'h00, 7'h02, 7'h04, 7'h08,
                                      7'h10, 7'h18, 7'h20, 7'h40};
   logic [1:0]  rs_q;
   logic [7:0]  m1_q;
   logic [4:0]  m2_q;
   logic [5:0]  dl_q;
   logic [15:0] s_q, l_q, p_q, er, ef;
   logic        wr, sel, pok;
   logic [5:0]  c, ix;
   logic [3:0]  ce_q;
   // checks wait four edges after the clock enable returns, since the
   // run-length counters here do not freeze with the block
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ce_q <= 4'h0;
      end else begin
         ce_q <= CE_IN ? {ce_q[2:0], 1'b1} : 4'h0;
      end
   end
   // shadow fields follow the same write strobe as the block
   assign c   = CONTROL_INPUT_IN;
   assign ix  = PADDR_IN[7:2];
   assign wr  = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & PSTRB_IN[0];
   assign pok = &(POWER_GOOD_FLAG_IN | {m2_q[1:0], m1_q});
   // edges from first sight of a pin change to the output change
   assign er = (dl_q[2:0] == 3'h0) ? 16'h0004 :
               16'(DMS[dl_q[2:0]] * MS_CYCLES + 5);
   assign ef = (dl_q[5:3] == 3'h0) ? 16'h0004 :
               16'(DMS[dl_q[5:3]] * MS_CYCLES + 5);
   // selected enable as the mux should see it
   always_comb begin
      case (m2_q[4:2])
         3'h0: sel = c[0];
         3'h1: sel = c[1];
         3'h2: sel = c[4];
         3'h3: sel = c[3];
         3'h4: sel = c[2];
         3'h5: sel = c[2] & c[3];
         3'h6: sel = c[5];
         default: sel = 1'b1;
      endcase
   end
   // register shadows
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         m1_q <= 8'h00;
         m2_q <= 5'h00;
         dl_q <= 6'h00;
      end else if (wr) begin
         if (ix == regl_pkg::REG_IDX_PG_MASK_MAIN) m1_q <= PWDATA_IN[7:0];
         if (ix == regl_pkg::REG_IDX_SRC_AND_MASK) m2_q <= PWDATA_IN[4:0];
         if (ix == regl_pkg::REG_IDX_EDGE_DELAY) dl_q <= PWDATA_IN[5:0];
      end
   end
   // run lengths wait for the reset copy, else they run two edges early
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rs_q <= 2'h0;
         s_q  <= 16'h0000;
         l_q  <= 16'h0000;
         p_q  <= 16'h0000;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
         if (rs_q[1]) begin
            s_q <= sel ? s_q + 16'h0001 : 16'h0000;
            l_q <= sel ? 16'h0000 : l_q + 16'h0001;
            p_q <= pok ? p_q + 16'h0001 : 16'h0000;
         end
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN || ce_q != 4'hF);
   property p_pg_block; (!pok) [*3] |=> !RAIL_ENABLE_OUT; endproperty
   a_pg_block: assert property (p_pg_block)
      else $error("rail on with a needed flag low");
   property p_pass;
      (rs_q[1] && pok && sel && dl_q[2:0] == 3'h0) [*4] |=> RAIL_ENABLE_OUT;
   endproperty
   a_pass: assert property (p_pass)
      else $error("rail off with source and flags good");
   property p_idle;
      (!sel && dl_q[5:3] == 3'h0) [*4] |=> !RAIL_ENABLE_OUT;
   endproperty
   a_idle: assert property (p_idle)
      else $error("rail on with source low");
   property p_const;
      (rs_q[1] && m2_q[4:2] == 3'h7 && pok && dl_q[2:0] == 3'h0) [*4]
         |=> RAIL_ENABLE_OUT;
   endproperty
   a_const: assert property (p_const)
      else $error("constant source did not enable");
   property p_rise_min;
      $rose(RAIL_ENABLE_OUT) && dl_q[2:0] != 3'h0 |-> s_q >= er;
   endproperty
   a_rise_min: assert property (p_rise_min)
      else $error("rise came early");
   property p_rise_at; s_q == er && p_q >= 16'h0003 |-> RAIL_ENABLE_OUT;
   endproperty
   a_rise_at: assert property (p_rise_at)
      else $error("rise came late");
   property p_fall_min;
      $fell(RAIL_ENABLE_OUT) && dl_q[5:3] != 3'h0 && p_q >= 16'h0003
         |-> l_q >= ef;
   endproperty
   a_fall_min: assert property (p_fall_min)
      else $error("fall came early");
   property p_fall_at; l_q == ef |-> !RAIL_ENABLE_OUT; endproperty
   a_fall_at: assert property (p_fall_at)
      else $error("fall came late");
endmodule // regl_sva
bind regl_top regl_sva #(.MS_CYCLES(MS_CYCLES), .ADDR_W(ADDR_W),
   .N_CTL(N_CTL), .N_PG(N_PG)) i_sva (.CLK_IN(CLK_IN),
   .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
   .PSTRB_IN(PSTRB_IN), .CONTROL_INPUT_IN(CONTROL_INPUT_IN),
   .POWER_GOOD_FLAG_IN(POWER_GOOD_FLAG_IN), .PREADY_OUT(PREADY_OUT),
   .RAIL_ENABLE_OUT(RAIL_ENABLE_OUT));

// ===== bench/regl_far_side.sv
// far side model: control pins and sibling power-good levels
`timescale 1ns/10ps
module regl_far_side (
   input  wire logic       clk_in,
   output logic [5:0]      ctl_out,
   output logic [9:0]      pg_out
);
   // pins idle low, siblings start up good
   initial begin
      ctl_out = 6'h00;
      pg_out  = 10'h3FF;
   end
   // levels move just after a rising edge, never mid-cycle
   task automatic drive(input logic [5:0] cv, input logic [9:0] gv);
      @(posedge clk_in);
      ctl_out <= cv;
      pg_out  <= gv;
   endtask
endmodule // regl_far_side

// ===== bench/test_rail_enable_gating_logic.sv
// bench for the rail five enable gating block
`timescale 1ns/10ps
module test_rail_enable_gating_logic;
   localparam int MS = 10;
   localparam logic [5:0] IM = regl_pkg::REG_IDX_PG_MASK_MAIN;
   localparam logic [5:0] IS = regl_pkg::REG_IDX_SRC_AND_MASK;
   localparam logic [5:0] ID = regl_pkg::REG_IDX_EDGE_DELAY;
   localparam int DMS [8] = '{7'h00, 7'h02, 7'h04, 7'h08,
                              7'h10, 7'h18, 7'h20, 7'h40};
   localparam int PIN [8] = '{3'h0, 3'h1, 3'h4, 3'h3,
                              3'h2, 3'h2, 3'h5, 3'h0};
   logic        clk, rst_n, psel, pen, pwr, rdy, err, rail, e, ce;
   logic [7:0]  pa;
   logic [31:0] pd, prd, rd;
   logic [3:0]  ps;
   logic [5:0]  ctl;
   logic [9:0]  pg;
   int          miscompares, samples_checked;
   regl_top #(.MS_CYCLES(MS)) i_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
      .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(pa), .PWDATA_IN(pd), .PSTRB_IN(ps),
      .CONTROL_INPUT_IN(ctl), .POWER_GOOD_FLAG_IN(pg), .PRDATA_OUT(prd),
      .PREADY_OUT(rdy), .PSLVERR_OUT(err), .RAIL_ENABLE_OUT(rail));
   regl_far_side i_far (.clk_in(clk), .ctl_out(ctl), .pg_out(pg));
   always #2.5 clk = ~clk;
   task automatic complete_run;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [5:0] ix,
                      input logic [31:0] d, input logic [3:0] s);
      int   n;
      logic ok;
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= {ix, 2'b00};
      pd   <= d;
      ps   <= s;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // look after each edge at what the next edge samples; no race
      do begin
         #1;
         ok = rdy;
         rd = prd;
         e  = err;
         @(posedge clk);
         n++;
      end while (ok !== 1'b1 && n < 50);
      psel <= 1'b0;
      pen  <= 1'b0;
      if (ok !== 1'b1) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [5:0] ix, input logic [31:0] d);
      apb(1'b1, ix, d, 4'hF);
   endtask
   task automatic rdchk(input logic [5:0] ix, input logic [31:0] x);
      apb(1'b0, ix, 32'h0000_0000, 4'h0);
      chk(rd === x && e === 1'b0, "read back");
   endtask
   // edges until the rail reaches v, bounded
   task automatic wrail(input logic v, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (rail !== v && n < 2000);
      if (rail !== v) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic t_regs;
      rdchk(IM, 32'h0000_0000);
      rdchk(IS, 32'h0000_0000);
      rdchk(ID, 32'h0000_0000);
      wr(IM, 32'hFFFF_FFFF);
      rdchk(IM, 32'h0000_00FF);
      wr(IS, 32'hFFFF_FFFF);
      rdchk(IS, 32'h0000_001F);
      wr(ID, 32'hFFFF_FFFF);
      rdchk(ID, 32'h0000_003F);
      apb(1'b1, ID, 32'h0000_0000, 4'h0);
      rdchk(ID, 32'h0000_003F);
      apb(1'b0, 6'h20, 32'h0000_0000, 4'h0);
      chk(e === 1'b1 && rd === 32'h0000_0000, "unmapped");
      wr(ID, 32'h0000_0000);
   endtask
   // each source code, with its own pins on and then at least one of them off
   task automatic t_src;
      logic [5:0] p;
      for (int c = 0; c < 8; c++) begin
         p = (c == 5) ? 6'h0C : 6'h01 << PIN[c];
         i_far.drive(6'h00, 10'h3FF);
         wr(IS, {27'h0, c[2:0], 2'b00});
         i_far.drive(p, 10'h3FF);
         wt(6);
         chk(rail === 1'b1, "source on");
         i_far.drive((c == 5) ? 6'h04 : ~p, 10'h3FF);
         wt(6);
         chk(rail === (c == 7), "source off");
      end
   endtask
   // every flag: masked low has no effect, unmasked low blocks
   task automatic t_mask;
      logic [9:0] m;
      for (int i = 0; i < 10; i++) begin
         m = ~(10'h001 << i);
         wr(IM, 32'h0000_00FF);
         wr(IS, 32'h0000_001F);
         i_far.drive(6'h00, m);
         wt(4);
         chk(rail === 1'b1, "masked flag");
         wr(IM, {24'h0, m[7:0]});
         wr(IS, {27'h0, 3'h7, m[9:8]});
         wt(2);
         chk(rail === 1'b0, "flag blocks");
      end
   endtask
   // all eight delay codes on both edges, then a short pulse
   task automatic t_delay;
      int n;
      wr(IM, 32'h0000_00FF);
      wr(IS, 32'h0000_0003);
      i_far.drive(6'h00, 10'h3FF);
      wt(6);
      for (int k = 0; k < 8; k++) begin
         wr(ID, {26'h0, k[2:0], k[2:0]});
         i_far.drive(6'h01, 10'h3FF);
         wrail(1'b1, n);
         chk(n == ((k == 0) ? 4 : DMS[k] * MS + 5), "rise");
         i_far.drive(6'h00, 10'h3FF);
         wrail(1'b0, n);
         chk(n == ((k == 0) ? 4 : DMS[k] * MS + 5), "fall");
      end
      wr(ID, 32'h0000_0001);
      i_far.drive(6'h01, 10'h3FF);
      wt(10);
      i_far.drive(6'h00, 10'h3FF);
      wt(40);
      chk(rail === 1'b0, "short pulse");
   endtask
   // clock enable low freezes the rail; status shows the enable path
   task automatic t_hold;
      wr(ID, 32'h0000_0000);
      i_far.drive(6'h01, 10'h3FF);
      wt(6);
      rdchk(6'h1F, 32'h0000_001B);
      @(posedge clk);
      ce <= 1'b0;
      i_far.drive(6'h00, 10'h3FF);
      wt(10);
      chk(rail === 1'b1, "held by enable");
      @(posedge clk);
      ce <= 1'b1;
      wt(6);
      chk(rail === 1'b0, "released");
      rdchk(6'h1F, 32'h0000_0008);
   endtask
   initial begin
      clk   = 1'b0;
      ce    = 1'b1;
      rst_n = 1'b0;
      psel  = 1'b0;
      pen   = 1'b0;
      pwr   = 1'b0;
      pa    = 8'h00;
      pd    = 32'h0000_0000;
      ps    = 4'h0;
      miscompares     = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wt(4);
      t_regs();
      t_src();
      t_mask();
      t_delay();
      t_hold();
      complete_run();
   end
endmodule // test_rail_enable_gating_logic
